// ==== verilog/otpspw_pkg.sv ====
// package for the otp self-program writer: register map, fields, timing
package otpspw_pkg;
    localparam logic [7:0] OTP_WRITE_CONTROL_ADDR   = 8'h2D;
    localparam logic [7:0] OTP_WRITE_DATA_LOW_ADDR  = 8'h2E;
    localparam logic [7:0] OTP_WRITE_DATA_HIGH_ADDR = 8'h2F;
    localparam logic [7:0] CTRL_RESET               = 8'h00;
    localparam logic [7:0] DATA_LOW_RESET           = 8'h00;
    localparam logic [6:0] DATA_HIGH_RESET          = 7'h00;
    localparam int         WRITE_GATE_BIT           = 3;
    localparam int         WRITE_TRIGGER_BIT        = 2;
    localparam int         WORD_W                   = 15;
    localparam int         PTR_W                    = 8;
    localparam int         CLK_HZ                   = 50_000_000;
    localparam int         WRITE_TIME_US            = 100;
    localparam int         WRITE_CYCLES             = WRITE_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [0:0]
    {
        OTPSPW_IDLE  = 1'b0,
        OTPSPW_WRITE = 1'b1
    } otpspw_state_t;

    // cpu side register access, one instruction per enabled cycle
    typedef struct packed
    {
        logic             wr;
        logic [7:0]       addr;
        logic [7:0]       wdata;
        logic             instr_end;
    } otpspw_cpu_t;

    // request to the otp array
    typedef struct packed
    {
        logic              prog;
        logic [PTR_W-1:0]  addr;
        logic [WORD_W-1:0] data;
    } otpspw_prog_t;
endpackage

// ==== verilog/otpspw_writer.sv ====
// otp self-program writer: control and data registers, write sequencer, table read
module otpspw_writer
    import otpspw_pkg::*;
#(
    parameter int WRITE_CLKS = WRITE_CYCLES
)
(
    input  wire logic              clk_i,          // system clock, 50 MHz
    input  wire logic              srst_i,         // synchronous reset, active high
    input  wire otpspw_cpu_t       cpu_i,          // register access from the cpu
    input  wire logic              instr_en_i,     // one pulse per instruction cycle
    input  wire logic [PTR_W-1:0]  table_ptr_i,    // table pointer, word in last page
    input  wire logic              table_rd_i,     // last_page_table_read pulse
    input  wire logic [WORD_W-1:0] otp_rdata_i,    // word from otp array
    output logic [7:0]             cpu_rdata_o,    // register read data
    output logic                   cpu_stall_o,    // cpu halted while programming
    output otpspw_prog_t           otp_prog_o,     // programming request to array
    output logic [7:0]             table_low_o,    // low byte of table read
    output logic [7:0]             table_high_byte_o // read-only high part
);
    logic                  write_gate;
    logic                  write_trigger;
    logic [7:0]            data_low;
    logic [6:0]            data_high;
    logic                  gate_prev_instr;
    otpspw_state_t         state;
    logic [31:0]           cnt;
    logic [7:0]            rdata;
    logic                  stall;
    otpspw_prog_t          prog;
    logic [7:0]            tlow;
    logic [7:0]            thigh;

    logic                  next_write_gate;
    logic                  next_write_trigger;
    logic [7:0]            next_data_low;
    logic [6:0]            next_data_high;
    logic                  next_gate_prev_instr;
    otpspw_state_t         next_state;
    logic [31:0]           next_cnt;
    logic [7:0]            next_rdata;
    logic                  next_stall;
    otpspw_prog_t          next_prog;
    logic [7:0]            next_tlow;
    logic [7:0]            next_thigh;

    logic                  ctrl_wr;
    logic                  set_gate;
    logic                  set_trig;
    logic                  start;
    logic                  done;

    assign ctrl_wr  = instr_en_i && cpu_i.wr && !stall && (cpu_i.addr == OTP_WRITE_CONTROL_ADDR);
    assign set_gate = ctrl_wr && cpu_i.wdata[WRITE_GATE_BIT];
    assign set_trig = ctrl_wr && cpu_i.wdata[WRITE_TRIGGER_BIT];
    // trigger only counts if the gate was set by the immediately preceding instruction
    assign start    = (state == OTPSPW_IDLE) && set_trig && write_gate && gate_prev_instr;
    assign done     = (state == OTPSPW_WRITE) && (cnt == 32'(WRITE_CLKS - 1));

    always_comb
    begin
        next_write_gate      = write_gate;
        next_write_trigger   = write_trigger;
        next_data_low        = data_low;
        next_data_high       = data_high;
        next_gate_prev_instr = gate_prev_instr;
        next_state           = state;
        next_cnt             = cnt;
        next_stall           = stall;
        next_prog            = prog;
        if (instr_en_i && !stall)
        begin
            // gate-then-trigger window lasts exactly one instruction
            next_gate_prev_instr = set_gate && !write_gate && !set_trig;
        end
        if (instr_en_i && cpu_i.wr && !stall)
        begin
            if (cpu_i.addr == OTP_WRITE_CONTROL_ADDR)
            begin
                next_write_gate = cpu_i.wdata[WRITE_GATE_BIT];
                // a bare trigger without a prepared gate stays clear
                next_write_trigger = start;
            end
            else if (cpu_i.addr == OTP_WRITE_DATA_LOW_ADDR)
            begin
                next_data_low = cpu_i.wdata;
            end
            else if (cpu_i.addr == OTP_WRITE_DATA_HIGH_ADDR)
            begin
                next_data_high = cpu_i.wdata[6:0];
            end
        end
        case (state)
            OTPSPW_IDLE:
            begin
                next_prog.prog = 1'b0;
                if (start)
                begin
                    next_state     = OTPSPW_WRITE;
                    next_cnt       = 32'h0000_0000;
                    next_stall     = 1'b1;
                    next_write_gate = 1'b1;
                    next_prog.prog = 1'b1;
                    next_prog.addr = table_ptr_i;
                    next_prog.data = {data_high, data_low};
                end
            end
            OTPSPW_WRITE:
            begin
                next_cnt = cnt + 32'h0000_0001;
                if (done)
                begin
                    next_state         = OTPSPW_IDLE;
                    next_stall         = 1'b0;
                    next_write_gate    = 1'b0;
                    next_write_trigger = 1'b0;
                    next_prog.prog     = 1'b0;
                end
            end
            default:
            begin
                next_state = OTPSPW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            write_gate      <= CTRL_RESET[WRITE_GATE_BIT];
            write_trigger   <= CTRL_RESET[WRITE_TRIGGER_BIT];
            data_low        <= DATA_LOW_RESET;
            data_high       <= DATA_HIGH_RESET;
            gate_prev_instr <= 1'b0;
            state           <= OTPSPW_IDLE;
            cnt             <= 32'h0000_0000;
            stall           <= 1'b0;
            prog            <= '0;
        end
        else
        begin
            write_gate      <= next_write_gate;
            write_trigger   <= next_write_trigger;
            data_low        <= next_data_low;
            data_high       <= next_data_high;
            gate_prev_instr <= next_gate_prev_instr;
            state           <= next_state;
            cnt             <= next_cnt;
            stall           <= next_stall;
            prog            <= next_prog;
        end
    end

    // register read and table read capture
    always_comb
    begin
        next_rdata = 8'h00;
        if (cpu_i.addr == OTP_WRITE_CONTROL_ADDR)
        begin
            next_rdata = {4'h0, write_gate, write_trigger, 2'h0};
        end
        else if (cpu_i.addr == OTP_WRITE_DATA_LOW_ADDR)
        begin
            next_rdata = data_low;
        end
        else if (cpu_i.addr == OTP_WRITE_DATA_HIGH_ADDR)
        begin
            next_rdata = {1'b0, data_high};
        end
        next_tlow  = tlow;
        next_thigh = thigh;
        if (table_rd_i && !stall)
        begin
            next_tlow  = otp_rdata_i[7:0];
            next_thigh = {1'b0, otp_rdata_i[WORD_W-1:8]};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata <= 8'h00;
            tlow  <= 8'h00;
            thigh <= 8'h00;
        end
        else
        begin
            rdata <= next_rdata;
            tlow  <= next_tlow;
            thigh <= next_thigh;
        end
    end

    assign cpu_rdata_o       = rdata;
    assign cpu_stall_o       = stall;
    assign otp_prog_o        = prog;
    assign table_low_o       = tlow;
    assign table_high_byte_o = thigh;

    // assertions
    // helper for the length check: cycles spent in the current stall run
    logic [31:0]           stall_len;
    logic [31:0]           next_stall_len;

    always_comb
    begin
        next_stall_len = 32'h0000_0000;
        if (stall)
        begin
            next_stall_len = stall_len + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            stall_len <= 32'h0000_0000;
        end
        else
        begin
            stall_len <= next_stall_len;
        end
    end

    sequence arm_s;
        instr_en_i && set_gate && !write_gate && !set_trig && !stall;
    endsequence

    sequence fire_s;
        instr_en_i && set_trig && !stall;
    endsequence

    no_gate_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(prog.prog) |-> $past(write_gate))
        else $error("programming started with gate clear");

    stall_on_start_a: assert property (@(posedge clk_i) disable iff (srst_i)
        start |=> stall && prog.prog && write_trigger)
        else $error("stall or trigger missing after start");

    end_clears_a: assert property (@(posedge clk_i) disable iff (srst_i)
        done |=> !write_gate && !write_trigger && !stall)
        else $error("bits not cleared at cycle end");

    trig_ignored_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ctrl_wr && set_trig && !write_gate) |=> !write_trigger)
        else $error("trigger accepted without gate");

    back_to_back_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (state == OTPSPW_IDLE) ##0 arm_s ##1 (fire_s or (!instr_en_i ##1 fire_s)
            or ((!instr_en_i)[*2] ##1 fire_s)) |=> stall)
        else $error("consecutive gate and trigger did not start");

    broken_pair_a: assert property (@(posedge clk_i) disable iff (srst_i)
        arm_s ##1 !instr_en_i ##1 (instr_en_i && !ctrl_wr) ##1 !instr_en_i ##1 fire_s
            |=> !stall)
        else $error("write started after a broken gate and trigger pair");

    gate_with_trig_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ctrl_wr && set_gate && set_trig && !write_gate) |=> !stall)
        else $error("gate and trigger in one instruction started a write");

    trig_holds_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(stall) |-> write_trigger throughout (stall [*2]))
        else $error("trigger dropped during write");

    addr_from_ptr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        start |=> prog.addr == $past(table_ptr_i) && prog.data == {$past(data_high), $past(data_low)})
        else $error("wrong address or data programmed");

    ctrl_read_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cpu_i.addr == OTP_WRITE_CONTROL_ADDR) |=> (rdata[7:4] == 4'h0) && (rdata[1:0] == 2'h0))
        else $error("unimplemented control bits read nonzero");

    high_read_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (table_rd_i && !stall) |=> thigh == {1'b0, $past(otp_rdata_i[WORD_W-1:8])}
            && tlow == $past(otp_rdata_i[7:0]))
        else $error("table read high byte wrong");

    data_locked_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (stall && instr_en_i && cpu_i.wr) |=> $stable(data_low) && $stable(data_high))
        else $error("data register changed during write");

    write_length_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(stall) |-> stall_len == 32'(WRITE_CLKS))
        else $error("write cycle length wrong");

    done_signal_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(write_trigger) |-> $fell(stall) && !prog.prog)
        else $error("trigger cleared before write finished");
endmodule

// ==== tb/otpspw_array_model.sv ====
// behavioural otp array: last-page words, each programmable once
module otpspw_array_model
    import otpspw_pkg::*;
(
    input  wire logic              clk_i,    // system clock
    input  wire otpspw_prog_t      prog_i,   // programming request
    input  wire logic [PTR_W-1:0]  ptr_i,    // table pointer
    output logic [WORD_W-1:0]      rdata_o   // addressed word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem [2**PTR_W];
    logic              used [2**PTR_W];
    logic              prog_q = 1'b0;
    initial
    begin
        foreach (mem[i])
        begin
            mem[i]  = '0;
            used[i] = 1'b0;
        end
    end
    // a second burn of a word is lost, as on real fuses
    always @(posedge clk_i)
    begin
        prog_q <= prog_i.prog;
        if (prog_i.prog && !prog_q && !used[prog_i.addr])
        begin
            mem[prog_i.addr]  <= prog_i.data;
            used[prog_i.addr] <= 1'b1;
        end
    end
    assign rdata_o = mem[ptr_i];
endmodule

// ==== tb/otpspw_writer_test.sv ====
// self-checking testbench for the otp self-program writer
module otpspw_writer_test
    import otpspw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 8;
    logic              clk_i, srst_i, instr_en_i, table_rd_i, cpu_stall_o;
    otpspw_cpu_t       cpu_i;
    otpspw_prog_t      otp_prog_o;
    logic [PTR_W-1:0]  table_ptr_i;
    logic [WORD_W-1:0] otp_rdata_i;
    logic [7:0]        cpu_rdata_o, table_low_o, table_high_byte_o, d_lo, d_hi;
    logic [31:0]       seed;
    logic [7:0]        vals [3] = '{8'hFF, 8'h04, 8'h0C};
    int                bad_count, checks, stall_cnt, stall_base;

    otpspw_writer #(.WRITE_CLKS(WC)) dut_u (.clk_i, .srst_i, .cpu_i, .instr_en_i, .table_ptr_i,
        .table_rd_i, .otp_rdata_i, .cpu_rdata_o, .cpu_stall_o, .otp_prog_o, .table_low_o,
        .table_high_byte_o);
    otpspw_array_model array_u (.clk_i, .prog_i(otp_prog_o), .ptr_i(table_ptr_i),
        .rdata_o(otp_rdata_i));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // a lone control write keeps only the gate bit
    function automatic logic [7:0] ctrl_view(input logic [7:0] w);
        return w & 8'h08;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cpu_i      <= '{wr: 1'b1, addr: a, wdata: d, instr_end: 1'b0};
        instr_en_i <= 1'b1;
        @(posedge clk_i);
        cpu_i.wr   <= 1'b0;
        instr_en_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        cpu_i.addr <= a;
        @(posedge clk_i);
        #1 chk({8'h00, cpu_rdata_o}, {8'h00, e});
    endtask
    task automatic close_out();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (cpu_stall_o === 1'b1)
            stall_cnt++;
    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        close_out();
    end

    initial
    begin
        srst_i = 1'b1;
        instr_en_i = 1'b0;
        table_rd_i = 1'b0;
        cpu_i = '0;
        table_ptr_i = '0;
        seed = 32'h0001_17FA;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(OTP_WRITE_CONTROL_ADDR, 8'h00);
        rd(OTP_WRITE_DATA_LOW_ADDR, 8'h00);
        rd(OTP_WRITE_DATA_HIGH_ADDR, 8'h00);
        $display("reset values done");
        for (int n = 0; n < 4; n++)
        begin
            seed = lfsr(seed);
            d_lo = (n == 0) ? 8'hFF : seed[7:0];
            d_hi = (n == 0) ? 8'hFF : seed[15:8];
            wr(OTP_WRITE_DATA_LOW_ADDR, d_lo);
            wr(OTP_WRITE_DATA_HIGH_ADDR, d_hi);
            rd(OTP_WRITE_DATA_LOW_ADDR, d_lo);
            rd(OTP_WRITE_DATA_HIGH_ADDR, d_hi & 8'h7F);
        end
        $display("data registers done");
        foreach (vals[i])
        begin
            wr(OTP_WRITE_CONTROL_ADDR, 8'h00);
            wr(OTP_WRITE_CONTROL_ADDR, vals[i]);
            chk({15'h0000, cpu_stall_o}, 16'h0000);
            rd(OTP_WRITE_CONTROL_ADDR, ctrl_view(vals[i]));
        end
        // gate, unrelated instruction, trigger: the pair is broken
        wr(OTP_WRITE_CONTROL_ADDR, 8'h00);
        wr(OTP_WRITE_CONTROL_ADDR, 8'h08);
        wr(OTP_WRITE_DATA_LOW_ADDR, d_lo);
        wr(OTP_WRITE_CONTROL_ADDR, 8'h0C);
        chk({15'h0000, cpu_stall_o}, 16'h0000);
        rd(OTP_WRITE_CONTROL_ADDR, 8'h08);
        $display("refused triggers done");
        for (int n = 0; n < 2; n++)
        begin
            seed = lfsr(seed);
            d_lo = seed[7:0];
            d_hi = seed[15:8];
            @(posedge clk_i);
            table_ptr_i <= (n == 0) ? seed[23:16] : 8'hFF;
            wr(OTP_WRITE_DATA_LOW_ADDR, d_lo);
            wr(OTP_WRITE_DATA_HIGH_ADDR, d_hi);
            wr(OTP_WRITE_CONTROL_ADDR, 8'h00);
            // no interrupts, sleep or supply-pin use around the pair
            wr(OTP_WRITE_CONTROL_ADDR, 8'h08);
            stall_base = stall_cnt;
            wr(OTP_WRITE_CONTROL_ADDR, 8'h0C);
            chk({15'h0000, cpu_stall_o}, 16'h0001);
            chk({15'h0000, otp_prog_o.prog}, 16'h0001);
            chk({8'h00, otp_prog_o.addr}, {8'h00, table_ptr_i});
            chk({1'b0, otp_prog_o.data}, {1'b0, d_hi[6:0], d_lo});
            rd(OTP_WRITE_CONTROL_ADDR, 8'h0C);
            wr(OTP_WRITE_DATA_LOW_ADDR, ~d_lo);
            for (int g = 0; g < 100 && cpu_stall_o !== 1'b0; g++)
                @(posedge clk_i);
            #1 chk(16'(stall_cnt - stall_base), WC[15:0]);
            chk({15'h0000, otp_prog_o.prog}, 16'h0000);
            rd(OTP_WRITE_CONTROL_ADDR, 8'h00);
            rd(OTP_WRITE_DATA_LOW_ADDR, d_lo);
            @(posedge clk_i);
            table_rd_i <= 1'b1;
            @(posedge clk_i);
            table_rd_i <= 1'b0;
            #1 chk({8'h00, table_low_o}, {8'h00, d_lo});
            chk({8'h00, table_high_byte_o}, {9'h000, d_hi[6:0]});
        end
        $display("programming and readback done");
        close_out();
    end
endmodule
